//--- aux_timer_capture_reload.sv
`default_nettype none


module aux_timer_capture_reload
#(
	parameter int CLOCKS_PER_MACHINE_CYCLE = aux_timer_pkg::CLOCKS_PER_MACHINE_CYCLE,
	parameter int EVENT_SAMPLE_PHASE       = aux_timer_pkg::EVENT_SAMPLE_PHASE,
	parameter int COUNT_WIDTH              = aux_timer_pkg::COUNT_WIDTH
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Special function register bus
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWrite,
	input  wire logic       sfrRead,
	input  wire logic [7:0] sfrWriteData,
	output var  logic [7:0] sfrReadData,
	// External pins
	input  wire logic       eventInputPin,
	input  wire logic       triggerPin,
	// Serial port clocking
	input  wire logic       otherTimerOverflow,
	output var  logic       overflowPulse,
	output logic            receiveClockPulse,
	output logic            transmitClockPulse,
	// Interrupt request
	output logic            interruptRequest
);

	localparam int PHASE_WIDTH = $clog2(CLOCKS_PER_MACHINE_CYCLE);
	localparam logic [PHASE_WIDTH-1:0] PHASE_LAST   = PHASE_WIDTH'(CLOCKS_PER_MACHINE_CYCLE - 1);
	localparam logic [PHASE_WIDTH-1:0] PHASE_SAMPLE = PHASE_WIDTH'(EVENT_SAMPLE_PHASE - 1);
	localparam logic [COUNT_WIDTH-1:0] COUNT_ALL_ONES = '1;

	if (COUNT_WIDTH != 16)
	begin : countWidthCheck
		$error("Counter must be exactly two bytes wide");
	end
	if (CLOCKS_PER_MACHINE_CYCLE < 2 || EVENT_SAMPLE_PHASE < 1 ||
		EVENT_SAMPLE_PHASE > CLOCKS_PER_MACHINE_CYCLE)
	begin : samplePhaseCheck
		$error("Sample phase must lie inside the machine cycle");
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register fields, reload/capture and count registers, decoded mode
	logic                    overflowFlag;
	logic                    externalFlag;
	logic                    receiveClockSelect;
	logic                    transmitClockSelect;
	logic                    triggerEnable;
	logic                    runControl;
	logic                    countSourceSelect;
	logic                    captureReloadSelect;
	logic [7:0]              reloadCaptureLow;
	logic [7:0]              reloadCaptureHigh;
	logic [COUNT_WIDTH-1:0]  count;
	aux_timer_pkg::mode_e    mode;
	logic                    baudMode;
	assign baudMode = receiveClockSelect | transmitClockSelect;

	always_comb
	begin
		if (!runControl)
			mode = aux_timer_pkg::MODE_OFF;
		else if (baudMode)
			mode = aux_timer_pkg::MODE_BAUD;
		else if (captureReloadSelect)
			mode = aux_timer_pkg::MODE_CAPTURE;
		else
			mode = aux_timer_pkg::MODE_RELOAD;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bus decode
	logic writeControl;
	logic writeReloadLow;
	logic writeReloadHigh;
	logic writeCountLow;
	logic writeCountHigh;
	assign writeControl    = sfrWrite && sfrAddr == aux_timer_pkg::ADDR_CONTROL;
	assign writeReloadLow  = sfrWrite && sfrAddr == aux_timer_pkg::ADDR_RELOAD_LOW;
	assign writeReloadHigh = sfrWrite && sfrAddr == aux_timer_pkg::ADDR_RELOAD_HIGH;
	assign writeCountLow   = sfrWrite && sfrAddr == aux_timer_pkg::ADDR_COUNT_LOW;
	assign writeCountHigh  = sfrWrite && sfrAddr == aux_timer_pkg::ADDR_COUNT_HIGH;

	////////////////////////////////////////////////////////////////////////////
	// Machine cycle divider
	logic [PHASE_WIDTH-1:0] phase;
	logic                   machineTick;
	logic                   sampleTick;
	always_ff @(posedge clk)
	begin
		if (rst)
			phase <= '0;
		else if (phase == PHASE_LAST)
			phase <= '0;
		else
			phase <= phase + PHASE_WIDTH'(1);
	end

	assign machineTick = phase == PHASE_LAST;
	assign sampleTick  = phase == PHASE_SAMPLE;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	logic eventMeta;
	logic eventSync;
	logic eventSample;
	logic eventSeen;
	logic triggerMeta;
	logic triggerSync;
	logic triggerPrev;
	logic triggerFall;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			eventMeta   <= 1'b0;
			eventSync   <= 1'b0;
			triggerMeta <= 1'b1;
			triggerSync <= 1'b1;
		end
		else
		begin
			eventMeta   <= eventInputPin;
			eventSync   <= eventMeta;
			triggerMeta <= triggerPin;
			triggerSync <= triggerMeta;
		end
	end

	// One sample per machine cycle; the edge takes effect at cycle end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			eventSample <= 1'b0;
			eventSeen   <= 1'b0;
		end
		else if (sampleTick)
		begin
			eventSample <= eventSync;
			eventSeen   <= eventSample && !eventSync;
		end
		else if (machineTick)
			eventSeen <= 1'b0;
	end

	// Trigger idles high so a pin held low at reset makes one falling edge after reset
	always_ff @(posedge clk)
	begin
		if (rst)
			triggerPrev <= 1'b1;
		else
			triggerPrev <= triggerSync;
	end

	assign triggerFall = triggerPrev && !triggerSync;

	////////////////////////////////////////////////////////////////////////////
	// Counter
	logic countStep;
	logic rollover;
	logic triggerAction;
	logic triggerReload;
	logic triggerCapture;
	logic reloadOnRollover;
	// Each source steps at most once per machine cycle
	assign countStep = mode != aux_timer_pkg::MODE_OFF && machineTick &&
		(countSourceSelect ? eventSeen : 1'b1);
	assign rollover  = countStep && count == COUNT_ALL_ONES;

	assign triggerAction  = triggerFall && triggerEnable && !baudMode &&
		mode != aux_timer_pkg::MODE_OFF;
	assign triggerReload  = triggerAction && mode == aux_timer_pkg::MODE_RELOAD;
	assign triggerCapture = triggerAction && mode == aux_timer_pkg::MODE_CAPTURE;

	// Capture mode wraps through zero as a plain timer
	assign reloadOnRollover = mode == aux_timer_pkg::MODE_RELOAD ||
		mode == aux_timer_pkg::MODE_BAUD;

	// Software writes to the count win over counting in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			count <= '0;
		else if (writeCountLow)
			count[7:0] <= sfrWriteData;
		else if (writeCountHigh)
			count[15:8] <= sfrWriteData;
		else if (triggerReload || (rollover && reloadOnRollover))
			count <= {reloadCaptureHigh, reloadCaptureLow};
		else if (countStep)
			count <= count + COUNT_WIDTH'(1);
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture and reload registers
	// A hardware capture wins over a software write in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reloadCaptureLow  <= aux_timer_pkg::BYTE_RESET;
			reloadCaptureHigh <= aux_timer_pkg::BYTE_RESET;
		end
		else if (triggerCapture)
		begin
			reloadCaptureLow  <= count[7:0];
			reloadCaptureHigh <= count[15:8];
		end
		else
		begin
			if (writeReloadLow)
				reloadCaptureLow <= sfrWriteData;
			if (writeReloadHigh)
				reloadCaptureHigh <= sfrWriteData;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register and flags
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			receiveClockSelect  <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_RECEIVE_CLOCK_SELECT];
			transmitClockSelect <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_TRANSMIT_CLOCK_SELECT];
			triggerEnable       <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_TRIGGER_ENABLE];
			runControl          <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_RUN_CONTROL];
			countSourceSelect   <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_COUNT_SOURCE_SELECT];
			captureReloadSelect <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_CAPTURE_RELOAD_SELECT];
		end
		else if (writeControl)
		begin
			receiveClockSelect  <= sfrWriteData[aux_timer_pkg::BIT_RECEIVE_CLOCK_SELECT];
			transmitClockSelect <= sfrWriteData[aux_timer_pkg::BIT_TRANSMIT_CLOCK_SELECT];
			triggerEnable       <= sfrWriteData[aux_timer_pkg::BIT_TRIGGER_ENABLE];
			runControl          <= sfrWriteData[aux_timer_pkg::BIT_RUN_CONTROL];
			countSourceSelect   <= sfrWriteData[aux_timer_pkg::BIT_COUNT_SOURCE_SELECT];
			captureReloadSelect <= sfrWriteData[aux_timer_pkg::BIT_CAPTURE_RELOAD_SELECT];
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			overflowFlag <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_OVERFLOW_FLAG];
		else if (rollover && !baudMode)
			overflowFlag <= 1'b1;
		else if (writeControl)
			overflowFlag <= sfrWriteData[aux_timer_pkg::BIT_OVERFLOW_FLAG];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			externalFlag <= aux_timer_pkg::CONTROL_RESET[aux_timer_pkg::BIT_EXTERNAL_FLAG];
		else if (triggerAction)
			externalFlag <= 1'b1;
		else if (writeControl)
			externalFlag <= sfrWriteData[aux_timer_pkg::BIT_EXTERNAL_FLAG];
	end

	assign interruptRequest = overflowFlag | externalFlag;

	////////////////////////////////////////////////////////////////////////////
	// Serial port clock routing
	always_ff @(posedge clk)
	begin
		if (rst)
			overflowPulse <= 1'b0;
		else
			overflowPulse <= rollover;
	end

	assign receiveClockPulse  = receiveClockSelect  ? overflowPulse : otherTimerOverflow;
	assign transmitClockPulse = transmitClockSelect ? overflowPulse : otherTimerOverflow;

	////////////////////////////////////////////////////////////////////////////
	// Register read-back, one cycle after the read strobe
	logic [7:0] controlValue;
	always_comb
	begin
		controlValue = aux_timer_pkg::CONTROL_RESET;
		controlValue[aux_timer_pkg::BIT_OVERFLOW_FLAG]         = overflowFlag;
		controlValue[aux_timer_pkg::BIT_EXTERNAL_FLAG]         = externalFlag;
		controlValue[aux_timer_pkg::BIT_RECEIVE_CLOCK_SELECT]  = receiveClockSelect;
		controlValue[aux_timer_pkg::BIT_TRANSMIT_CLOCK_SELECT] = transmitClockSelect;
		controlValue[aux_timer_pkg::BIT_TRIGGER_ENABLE]        = triggerEnable;
		controlValue[aux_timer_pkg::BIT_RUN_CONTROL]           = runControl;
		controlValue[aux_timer_pkg::BIT_COUNT_SOURCE_SELECT]   = countSourceSelect;
		controlValue[aux_timer_pkg::BIT_CAPTURE_RELOAD_SELECT] = captureReloadSelect;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			sfrReadData <= aux_timer_pkg::UNMAPPED_READ;
		else if (sfrRead)
		begin
			case (sfrAddr)
				aux_timer_pkg::ADDR_CONTROL:     sfrReadData <= controlValue;
				aux_timer_pkg::ADDR_RELOAD_LOW:  sfrReadData <= reloadCaptureLow;
				aux_timer_pkg::ADDR_RELOAD_HIGH: sfrReadData <= reloadCaptureHigh;
				aux_timer_pkg::ADDR_COUNT_LOW:   sfrReadData <= count[7:0];
				aux_timer_pkg::ADDR_COUNT_HIGH:  sfrReadData <= count[15:8];
				default:                         sfrReadData <= aux_timer_pkg::UNMAPPED_READ;
			endcase
		end
	end

endmodule // aux_timer_capture_reload

`default_nettype wire

//--- aux_timer_pkg.sv
`default_nettype none

package aux_timer_pkg;

	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_CONTROL       = 8'hC8;
	localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LOW     = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hCD;

	// Control register bit positions
	localparam int BIT_OVERFLOW_FLAG          = 7;
	localparam int BIT_EXTERNAL_FLAG          = 6;
	localparam int BIT_RECEIVE_CLOCK_SELECT   = 5;
	localparam int BIT_TRANSMIT_CLOCK_SELECT  = 4;
	localparam int BIT_TRIGGER_ENABLE         = 3;
	localparam int BIT_RUN_CONTROL            = 2;
	localparam int BIT_COUNT_SOURCE_SELECT    = 1;
	localparam int BIT_CAPTURE_RELOAD_SELECT  = 0;

	// Reset values
	localparam logic [7:0]  CONTROL_RESET     = 8'h00;
	localparam logic [7:0]  BYTE_RESET        = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

	// Machine cycle timing: clocks per machine cycle, sampling phase; counter width
	localparam int CLOCKS_PER_MACHINE_CYCLE   = 12;
	localparam int EVENT_SAMPLE_PHASE         = 9;
	localparam int COUNT_WIDTH                = 16;

	// Operating mode decoded from the control bits
	typedef enum logic [1:0]
	{
		MODE_OFF     = 2'b00,
		MODE_RELOAD  = 2'b01,
		MODE_CAPTURE = 2'b11,
		MODE_BAUD    = 2'b10
	} mode_e;

endpackage

`default_nettype wire

//--- aux_timer_assertions.sv
`default_nettype none

module aux_timer_assertions
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Register bus
	input wire logic [7:0] sfrAddr,
	input wire logic       sfrWrite,
	input wire logic       sfrRead,
	input wire logic [7:0] sfrWriteData,
	input wire logic [7:0] sfrReadData,
	// Timer outputs and the other timer overflow input
	input wire logic       otherTimerOverflow,
	input wire logic       overflowPulse,
	input wire logic       receiveClockPulse,
	input wire logic       transmitClockPulse,
	input wire logic       interruptRequest
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [7:0] ctl;
	logic       ctlWrite;
	logic       baudSel;

	////////////////////////////////////////////////////////////////
	// Software view of control; flag bits are not used from it
	assign ctlWrite = sfrWrite && sfrAddr == 8'hC8;
	assign baudSel = ctl[5] | ctl[4];
	always_ff @(posedge clk)
		if (rst)
			ctl <= 8'h00;
		else if (ctlWrite)
			ctl <= sfrWriteData;

	////////////////////////////////////////////////////////////////
	sequence s_unmapped_read;
		sfrRead && (sfrAddr < 8'hC8 || sfrAddr == 8'hC9 || sfrAddr > 8'hCD);
	endsequence
	// Stopped for three cycles, so no rollover can be in flight
	sequence s_stopped;
		!ctl[2] && !$past(ctl[2]) && !$past(ctl[2], 2);
	endsequence
	sequence s_baud_idle;
		baudSel && !interruptRequest && !ctlWrite;
	endsequence

	a_read_unmapped: assert property (s_unmapped_read |=> sfrReadData == 8'h00)
		else $error("unmapped read not zero");
	a_read_hold: assert property (!sfrRead |=> $stable(sfrReadData))
		else $error("read data changed without read");
	a_rx_route: assert property (receiveClockPulse == (ctl[5] ? overflowPulse : otherTimerOverflow))
		else $error("receive clock source wrong");
	a_tx_route: assert property (transmitClockPulse == (ctl[4] ? overflowPulse : otherTimerOverflow))
		else $error("transmit clock source wrong");
	a_pulse_single: assert property (overflowPulse |=> !overflowPulse [*8])
		else $error("overflow pulse too long");
	a_ovf_flag: assert property (overflowPulse && !$past(baudSel) |-> interruptRequest)
		else $error("overflow did not raise request");
	a_baud_noflag: assert property (overflowPulse && $past(baudSel) && !$past(interruptRequest)
		&& !$past(sfrWrite) |-> !interruptRequest)
		else $error("overflow flag set in baud mode");
	a_off_quiet: assert property (s_stopped |-> !overflowPulse)
		else $error("stopped timer rolled over");
	a_baud_quiet: assert property (s_baud_idle |=> !interruptRequest)
		else $error("trigger acted in baud mode");
endmodule // aux_timer_assertions

`default_nettype wire

//--- aux_pins_model.sv
`default_nettype none

module aux_pins_model
(
	// Clock
	input  wire logic clk,
	// Pins toward the timer
	output var  logic eventInputPin,
	output var  logic triggerPin,
	output var  logic otherTimerOverflow
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		eventInputPin = 1'b0;
		triggerPin = 1'b1;
		otherTimerOverflow = 1'b0;
	end

	// Other timer fires at random so the routing is seen both ways
	always @(negedge clk)
		otherTimerOverflow <= ($urandom % 5) == 0;

	// Each level held two machine cycles so the sampler sees both
	task automatic pulseEvent();
		eventInputPin = 1'b1;
		repeat (24) @(negedge clk);
		eventInputPin = 1'b0;
		repeat (24) @(negedge clk);
	endtask

	task automatic fallTrigger();
		triggerPin = 1'b0;
		repeat (4) @(negedge clk);
		triggerPin = 1'b1;
		repeat (4) @(negedge clk);
	endtask
endmodule // aux_pins_model

`default_nettype wire

//--- aux_timer_capture_reload_tb.sv
`default_nettype none

module aux_timer_capture_reload_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk;
	logic        rst;
	logic [7:0]  sfrAddr;
	logic        sfrWrite;
	logic        sfrRead;
	logic [7:0]  sfrWriteData;
	logic [7:0]  sfrReadData;
	logic        eventInputPin;
	logic        triggerPin;
	logic        otherTimerOverflow;
	logic        overflowPulse;
	logic        receiveClockPulse;
	logic        transmitClockPulse;
	logic        interruptRequest;
	int          errCount = 0;
	int          checkCount = 0;
	int          expCount;
	logic [15:0] rl;
	logic [7:0]  m;
	logic [7:0]  modes [4] = '{8'h05, 8'h1D, 8'h2C, 8'h3D};

	aux_timer_capture_reload dut (.clk, .rst, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .sfrReadData,
		.eventInputPin, .triggerPin, .otherTimerOverflow, .overflowPulse, .receiveClockPulse,
		.transmitClockPulse, .interruptRequest);
	aux_pins_model pins (.clk, .eventInputPin, .triggerPin, .otherTimerOverflow);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic endSim();
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			errCount++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp);
		chkByte({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrWriteData = d;
		sfrWrite = 1'b1;
		@(negedge clk);
		sfrWrite = 1'b0;
	endtask

	// Data is registered at the read edge, so it is settled by the next falling edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		sfrAddr = a;
		sfrRead = 1'b1;
		@(negedge clk);
		sfrRead = 1'b0;
		chkByte(sfrReadData, exp);
	endtask

	task automatic waitOvf();
		for (int k = 0; k < 100 && overflowPulse !== 1'b1; k++)
			@(negedge clk);
		chkBit(overflowPulse, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		sfrAddr = 8'h00;
		sfrWrite = 1'b0;
		sfrRead = 1'b0;
		sfrWriteData = 8'h00;
		void'($urandom(32'hF146));
		repeat (8) @(negedge clk);
		rst = 1'b0;
		for (int a = 8'hC8; a <= 8'hCD; a++)
			rd(8'(a), 8'h00);
		// Reload from a random preset; low byte kept small so no carry follows
		rl = 16'($urandom) & 16'hFF7F;
		wr(8'hCA, rl[7:0]);
		wr(8'hCB, rl[15:8]);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFE);
		wr(8'hC8, 8'h04);
		waitOvf();
		rd(8'hC8, 8'h84);
		chkBit(interruptRequest, 1'b1);
		wr(8'hC8, 8'h00);
		chkBit(interruptRequest, 1'b0);
		rd(8'hCD, rl[15:8]);
		// Capture wrap, then the three serial selects with triggers ignored
		foreach (modes[i])
		begin
			m = modes[i];
			wr(8'hCB, 8'hFF);
			wr(8'hCA, 8'hF0);
			wr(8'hCD, 8'hFF);
			wr(8'hCC, 8'hFE);
			wr(8'hC8, m);
			waitOvf();
			pins.fallTrigger();
			rd(8'hCD, (m[5:4] == 2'b00) ? 8'h00 : 8'hFF);
			rd(8'hC8, m | ((m[5:4] == 2'b00) ? 8'h80 : 8'h00));
			wr(8'hC8, 8'h00);
		end
		// Event source with no events holds the count steady for capture, then for trigger reload
		rl = 16'($urandom);
		wr(8'hCC, rl[7:0]);
		wr(8'hCD, rl[15:8]);
		wr(8'hC8, 8'h0F);
		pins.fallTrigger();
		rd(8'hCA, rl[7:0]);
		rd(8'hCB, rl[15:8]);
		rd(8'hC8, 8'h4F);
		chkBit(interruptRequest, 1'b1);
		rl = 16'($urandom);
		wr(8'hCA, rl[7:0]);
		wr(8'hCB, rl[15:8]);
		wr(8'hC8, 8'h0E);
		pins.fallTrigger();
		rd(8'hCC, rl[7:0]);
		rd(8'hCD, rl[15:8]);
		rd(8'hC8, 8'h4E);
		// Counting pin events
		wr(8'hC8, 8'h06);
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		expCount = 1 + $urandom % 3;
		repeat (expCount) pins.pulseEvent();
		rd(8'hCC, 8'(expCount));
		wr(8'hC8, 8'h0A);
		pins.pulseEvent();
		pins.fallTrigger();
		rd(8'hCC, 8'(expCount));
		rd(8'hC8, 8'h0A);
		endSim();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		errCount++;
		endSim();
	end
endmodule // aux_timer_capture_reload_tb

bind aux_timer_capture_reload aux_timer_assertions chk (.clk, .rst, .sfrAddr, .sfrWrite, .sfrRead,
	.sfrWriteData, .sfrReadData, .otherTimerOverflow, .overflowPulse, .receiveClockPulse,
	.transmitClockPulse, .interruptRequest);

`default_nettype wire
